// ==== rtl/ret_axil_slave.sv ====
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ns
`include "ret_regs.svh"
module ret_axil_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus
  input wire ret_pkg::ret_axi_req_s axiReq,
  output ret_pkg::ret_axi_rsp_s axiRsp,
  // Register file side
  output ret_pkg::ret_wr_s wr,
  input wire logic wrOk,
  output logic [`RET_ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);
  ret_pkg::ret_slv_state_s q, n;

  always_comb
  begin
    n = q;
    wr = '0;
    axiRsp.awready = !q.awHeld && !q.bvalid;
    axiRsp.wready = !q.wHeld && !q.bvalid;
    axiRsp.bvalid = q.bvalid;
    axiRsp.bresp = q.bresp;
    axiRsp.arready = !q.rvalid;
    axiRsp.rvalid = q.rvalid;
    axiRsp.rdata = q.rdata;
    axiRsp.rresp = q.rresp;
    rdAddr = axiReq.araddr;
    if (axiReq.awvalid && axiRsp.awready)
    begin
      n.awHeld = 1'b1;
      n.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiRsp.wready)
    begin
      n.wHeld = 1'b1;
      n.wData = axiReq.wdata;
      n.wStrb = axiReq.wstrb;
    end
    // Commit only once both halves are held, so arrival order is free
    if (q.awHeld && q.wHeld && !q.bvalid)
    begin
      wr.strobe = 1'b1;
      wr.addr = q.awAddr;
      wr.data = q.wData;
      wr.strb = q.wStrb;
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wrOk ? `RET_RESP_OKAY : `RET_RESP_SLVERR;
    end
    if (q.bvalid && axiReq.bready)
      n.bvalid = 1'b0;
    if (q.rvalid && axiReq.rready)
      n.rvalid = 1'b0;
    if (axiReq.arvalid && axiRsp.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = rdOk ? rdData : 32'h0;
      n.rresp = rdOk ? `RET_RESP_OKAY : `RET_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= n;
  end
endmodule

// ==== rtl/ret_event_timer.sv ====
// Event-driven timer pair of the contactless frontend with AXI4-Lite registers
// What this block does
// [RQ1] Timer zero divider codes 0..7 give 6.78 MHz halving down to 53 kHz.
// [RQ2] Divider off, the default, makes timer zero count at 13.56 MHz.
// [RQ3] Divider on makes timer zero count at the selected divided rate.
// [RQ4] Without auto-restart timer zero stops at expiry holding zero.
// [RQ5] With auto-restart timer zero reloads its preset and keeps counting.
// [RQ6] Timer zero does nothing while its enable bit is clear.
// [RQ7] Timer one may halt after a frame began and four bits arrived.
// [RQ8] That receive halt lags by a delay set by the active protocol.
// [RQ9] Timer one may halt when a transmission begins.
// [RQ10] Timer one may halt when a foreign field appears.
// [RQ11] Timer one may halt when a foreign field disappears.
// [RQ12] Timer one may halt when the own field is switched on.
// [RQ13] Timer one may halt when the own field is switched off.
// [RQ14] Timer one may launch when the first bit of a frame arrives.
// [RQ15] Timer one may launch when an incoming frame completes.
// [RQ16] Timer one may launch when a transmission starts.
// [RQ17] Each timer shows a 20-bit count and a running flag.
// [RQ18] Writing the immediate-start bit starts that timer at once.
// [RQ19] All setup fields reset to zero: timers off, undivided, no events.
// [RQ20] Any one of several selected events triggers the start or stop.
`timescale 1ns/1ns
`include "ret_regs.svh"
module ret_event_timer #(
  parameter int unsigned PROTO_DLY_NS0 = 100,
  parameter int unsigned PROTO_DLY_NS1 = 500,
  parameter int unsigned PROTO_DLY_NS2 = 1000,
  parameter int unsigned PROTO_DLY_NS3 = 2000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register bus
  input wire ret_pkg::ret_axi_req_s axiReq,
  output ret_pkg::ret_axi_rsp_s axiRsp,
  // RF front levels, asynchronous to clk_sys
  input wire ret_pkg::ret_rf_s rfIn,
  // Active protocol from the protocol engine, on clk_sys
  input wire logic [1:0] protocolSel
);
  localparam int unsigned DLY_CYC0 =
    (PROTO_DLY_NS0 + `RET_CLK_PERIOD_NS - 1) / `RET_CLK_PERIOD_NS;
  localparam int unsigned DLY_CYC1 =
    (PROTO_DLY_NS1 + `RET_CLK_PERIOD_NS - 1) / `RET_CLK_PERIOD_NS;
  localparam int unsigned DLY_CYC2 =
    (PROTO_DLY_NS2 + `RET_CLK_PERIOD_NS - 1) / `RET_CLK_PERIOD_NS;
  localparam int unsigned DLY_CYC3 =
    (PROTO_DLY_NS3 + `RET_CLK_PERIOD_NS - 1) / `RET_CLK_PERIOD_NS;
  localparam int unsigned DLY_MAX = (1 << `RET_DLY_W) - 1;

  if (DLY_CYC0 < 1 || DLY_CYC1 < 1 || DLY_CYC2 < 1 || DLY_CYC3 < 1)
    $error("ret_event_timer: protocol delays must be at least one cycle");
  if (DLY_CYC0 > DLY_MAX || DLY_CYC1 > DLY_MAX ||
      DLY_CYC2 > DLY_MAX || DLY_CYC3 > DLY_MAX)
    $error("ret_event_timer: protocol delay exceeds the delay counter");

  typedef struct packed {
    ret_pkg::ret_rf_s s1;
    ret_pkg::ret_rf_s s2;
    ret_pkg::ret_rf_s s3;
    ret_pkg::ret_rf_s stable;
    logic [31:0] setup0;
    logic [31:0] setup1;
    logic [`RET_CNT_W-1:0] reload0;
    logic [`RET_CNT_W-1:0] reload1;
    logic now0;
    logic now1;
    logic [`RET_ACC_W-1:0] acc;
    logic clifTick;
    logic dlyBusy;
    logic [`RET_DLY_W-1:0] dlyCnt;
  } ret_top_state_s;

  ret_top_state_s q, n;
  ret_pkg::ret_wr_s wr;
  logic wrOk;
  logic [`RET_ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdOk;
  ret_pkg::ret_rf_s agree;
  ret_pkg::ret_rf_s rise;
  ret_pkg::ret_rf_s fall;
  logic [`RET_ACC_W-1:0] accSum;
  logic launch1;
  logic halt1;
  logic rxHalt;
  logic [`RET_CNT_W-1:0] cnt0;
  logic [`RET_CNT_W-1:0] cnt1;
  logic run0;
  logic run1;

  function automatic logic [3:0] regIdx(input logic [`RET_ADDR_W-1:0] addr);
    regIdx = addr[`RET_ADDR_W-1:2];
  endfunction

  function automatic logic regMapped(input logic [3:0] idx);
    case (idx)
      `RET_IDX_T0_STATUS,
      `RET_IDX_T1_STATUS,
      `RET_IDX_T0_RELOAD,
      `RET_IDX_T1_RELOAD,
      `RET_IDX_T0_SETUP,
      `RET_IDX_T1_SETUP: regMapped = 1'b1;
      default: regMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        merge[b*8 +: 8] = val[b*8 +: 8];
    end
  endfunction

  function automatic logic [`RET_DLY_W-1:0] protoDly(input logic [1:0] sel);
    case (sel)
      2'h0: protoDly = `RET_DLY_W'(DLY_CYC0);
      2'h1: protoDly = `RET_DLY_W'(DLY_CYC1);
      2'h2: protoDly = `RET_DLY_W'(DLY_CYC2);
      default: protoDly = `RET_DLY_W'(DLY_CYC3);
    endcase
  endfunction

  ret_axil_slave slave (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .wr(wr),
    .wrOk(wrOk),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  // Register read mux; unused upper bits read as zero
  always_comb
  begin
    rdOk = regMapped(regIdx(rdAddr));
    case (regIdx(rdAddr))
      `RET_IDX_T0_STATUS: rdData = 32'({run0, cnt0}); // [RQ17]
      `RET_IDX_T1_STATUS: rdData = 32'({run1, cnt1}); // [RQ17]
      `RET_IDX_T0_RELOAD: rdData = 32'(q.reload0);
      `RET_IDX_T1_RELOAD: rdData = 32'(q.reload1);
      `RET_IDX_T0_SETUP: rdData = q.setup0;
      `RET_IDX_T1_SETUP: rdData = q.setup1;
      default: rdData = 32'h0;
    endcase
  end

  assign wrOk = regMapped(regIdx(wr.addr));

  always_comb
  begin
    n = q;
    // Three-stage synchroniser; a change counts once stages two and three agree
    n.s1 = rfIn;
    n.s2 = q.s1;
    n.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    n.stable = (q.s3 & agree) | (q.stable & ~agree);
    rise = n.stable & ~q.stable;
    fall = ~n.stable & q.stable;

    // Fractional accumulator gives an average 13.56 MHz enable from 20 MHz;
    // single ticks jitter by one system cycle, long spans stay exact
    accSum = q.acc + `RET_CONTACTLESS_INTERFACE_CLOCK_KHZ;
    if (accSum >= `RET_CLK_KHZ)
    begin
      n.acc = accSum - `RET_CLK_KHZ;
      n.clifTick = 1'b1; // [RQ2]
    end
    else
    begin
      n.acc = accSum;
      n.clifTick = 1'b0;
    end

    // Receive halt waits out the protocol-dependent lag after four bits
    rxHalt = 1'b0;
    if (q.dlyBusy)
    begin
      if (q.dlyCnt <= `RET_DLY_W'(1))
      begin
        n.dlyBusy = 1'b0;
        rxHalt = 1'b1; // [RQ8]
      end
      else
        n.dlyCnt = q.dlyCnt - 1'b1;
    end
    if (rise.rxNibble && q.setup1[`RET_F_HALT_RXB])
    begin
      n.dlyBusy = 1'b1; // [RQ7]
      n.dlyCnt = protoDly(protocolSel); // [RQ8]
    end

    // Any selected event suffices
    halt1 = rxHalt ||
      (rise.txBusy && q.setup1[`RET_F_HALT_TXB]) || // [RQ9] [RQ20]
      (rise.extField && q.setup1[`RET_F_HALT_FOR_UP]) || // [RQ10]
      (fall.extField && q.setup1[`RET_F_HALT_FOR_DN]) || // [RQ11]
      (rise.ownField && q.setup1[`RET_F_HALT_OWN_UP]) || // [RQ12]
      (fall.ownField && q.setup1[`RET_F_HALT_OWN_DN]); // [RQ13]
    launch1 = q.now1 ||
      (rise.rxBusy && q.setup1[`RET_F_LAUNCH_RXB]) || // [RQ14] [RQ20]
      (fall.rxBusy && q.setup1[`RET_F_LAUNCH_RXE]) || // [RQ15]
      (rise.txBusy && q.setup1[`RET_F_LAUNCH_TXB]); // [RQ16]

    // Immediate start is a write-only pulse, delayed one cycle so that
    // an enable written in the same access is already in force
    n.now0 = 1'b0;
    n.now1 = 1'b0;
    if (wr.strobe)
    begin
      case (regIdx(wr.addr))
        `RET_IDX_T0_SETUP:
        begin
          n.setup0 = merge(q.setup0, wr.data, wr.strb) & `RET_T0_SETUP_MASK;
          n.now0 = wr.strb[0] && wr.data[`RET_F_NOW]; // [RQ18]
        end
        `RET_IDX_T1_SETUP:
        begin
          n.setup1 = merge(q.setup1, wr.data, wr.strb) & `RET_T1_SETUP_MASK;
          n.now1 = wr.strb[0] && wr.data[`RET_F_NOW]; // [RQ18]
        end
        `RET_IDX_T0_RELOAD:
          n.reload0 = `RET_CNT_W'(merge(32'(q.reload0), wr.data, wr.strb));
        `RET_IDX_T1_RELOAD:
          n.reload1 = `RET_CNT_W'(merge(32'(q.reload1), wr.data, wr.strb));
        default:
          n.setup0 = q.setup0;
      endcase
    end
  end

  // All setup fields clear on reset
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0; // [RQ19]
    else
      q <= n;
  end

  // Timer zero has no event inputs here; only the immediate start drives it
  ret_timer #(
    .WIDTH(`RET_CNT_W),
    .PRE_W(`RET_PRE_W)
  ) timerZero (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clifTick(q.clifTick),
    .on(q.setup0[`RET_F_ON]), // [RQ6]
    .autoRestart(q.setup0[`RET_F_AUTO]), // [RQ4] [RQ5]
    .divOn(q.setup0[`RET_F_DIVON]), // [RQ2] [RQ3]
    .divSel(q.setup0[`RET_F_DIVSEL_HI:`RET_F_DIVSEL_LO]), // [RQ1]
    .reload(q.reload0),
    .start(q.now0), // [RQ18]
    .stop(1'b0),
    .count(cnt0),
    .running(run0)
  );

  ret_timer #(
    .WIDTH(`RET_CNT_W),
    .PRE_W(`RET_PRE_W)
  ) timerOne (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clifTick(q.clifTick),
    .on(q.setup1[`RET_F_ON]),
    .autoRestart(q.setup1[`RET_F_AUTO]),
    .divOn(q.setup1[`RET_F_DIVON]),
    .divSel(q.setup1[`RET_F_DIVSEL_HI:`RET_F_DIVSEL_LO]),
    .reload(q.reload1),
    .start(launch1), // [RQ14] [RQ15] [RQ16]
    .stop(halt1), // [RQ7] [RQ9] [RQ10] [RQ11] [RQ12] [RQ13]
    .count(cnt1),
    .running(run1)
  );
endmodule

// ==== rtl/ret_pkg.sv ====
// Types shared by the event timer pair and its bus slave
`include "ret_regs.svh"
package ret_pkg;
  typedef struct packed {
    logic awvalid;
    logic [`RET_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`RET_ADDR_W-1:0] araddr;
    logic rready;
  } ret_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ret_axi_rsp_s;
  typedef struct packed {
    logic rxBusy;
    logic rxNibble;
    logic txBusy;
    logic extField;
    logic ownField;
  } ret_rf_s;
  typedef struct packed {
    logic strobe;
    logic [`RET_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ret_wr_s;
  typedef struct packed {
    logic awHeld;
    logic [`RET_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ret_slv_state_s;
endpackage

// ==== rtl/ret_regs.svh ====
// Register indices, field positions and timing constants of the event timer pair
`ifndef RET_REGS_SVH
`define RET_REGS_SVH
`define RET_ADDR_W 6
`define RET_IDX_T0_STATUS 4'h8
`define RET_IDX_T1_STATUS 4'h9
`define RET_IDX_T0_RELOAD 4'hb
`define RET_IDX_T1_RELOAD 4'hc
`define RET_IDX_T0_SETUP 4'he
`define RET_IDX_T1_SETUP 4'hf
`define RET_CNT_W 20
`define RET_T0_SETUP_MASK 32'h0000003f
`define RET_T1_SETUP_MASK 32'h001ff03f
`define RET_F_ON 0
`define RET_F_AUTO 1
`define RET_F_DIVON 2
`define RET_F_DIVSEL_LO 3
`define RET_F_DIVSEL_HI 5
`define RET_F_NOW 6
`define RET_F_LAUNCH_TXB 12
`define RET_F_LAUNCH_RXE 13
`define RET_F_LAUNCH_RXB 14
`define RET_F_HALT_OWN_DN 15
`define RET_F_HALT_OWN_UP 16
`define RET_F_HALT_FOR_DN 17
`define RET_F_HALT_FOR_UP 18
`define RET_F_HALT_TXB 19
`define RET_F_HALT_RXB 20
`define RET_ACC_W 16
`define RET_CLK_KHZ 16'h4e20
`define RET_CONTACTLESS_INTERFACE_CLOCK_KHZ 16'h34f8
`define RET_CLK_PERIOD_NS 50
`define RET_PRE_W 8
`define RET_DLY_W 8
`define RET_RESP_OKAY 2'h0
`define RET_RESP_SLVERR 2'h2
`endif

// ==== rtl/ret_timer.sv ====
// One 20-bit down-counting timer with prescaler, reload and start/stop
`timescale 1ns/1ns
`include "ret_regs.svh"
module ret_timer #(
  parameter int unsigned WIDTH = `RET_CNT_W,
  parameter int unsigned PRE_W = `RET_PRE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Contactless clock enable
  input wire logic clifTick,
  // Configuration
  input wire logic on,
  input wire logic autoRestart,
  input wire logic divOn,
  input wire logic [2:0] divSel,
  input wire logic [WIDTH-1:0] reload,
  // Events
  input wire logic start,
  input wire logic stop,
  // Status
  output logic [WIDTH-1:0] count,
  output logic running
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic run;
    logic [PRE_W-1:0] pre;
  } ret_tmr_state_s;

  ret_tmr_state_s q, n;
  logic [PRE_W-1:0] divMask;
  logic tick;

  if (PRE_W < 8 || WIDTH < 2)
    $error("ret_timer: PRE_W must be at least 8 and WIDTH at least 2");

  // Divide by 2^(sel+1): code 0 halves the contactless rate
  function automatic logic [PRE_W-1:0] maskOf(input logic [2:0] sel);
    maskOf = {PRE_W{1'b1}} >> (PRE_W - 1 - int'(sel));
  endfunction

  always_comb
  begin
    n = q;
    divMask = maskOf(divSel); // [RQ1]
    tick = clifTick && (!divOn || ((q.pre & divMask) == divMask)); // [RQ2] [RQ3]
    if (clifTick)
      n.pre = q.pre + 1'b1;
    if (!on)
      n.run = 1'b0; // [RQ6]
    else if (stop)
      n.run = 1'b0;
    else if (start)
    begin
      n.run = 1'b1;
      n.cnt = reload;
      n.pre = '0;
    end
    else if (q.run && tick)
    begin
      if (q.cnt <= WIDTH'(1))
      begin
        if (autoRestart)
          n.cnt = reload; // [RQ5]
        else
        begin
          n.cnt = '0; // [RQ4]
          n.run = 1'b0;
        end
      end
      else
        n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= n;
  end

  assign count = q.cnt;
  assign running = q.run; // [RQ17]
endmodule

// ==== verif/ret_event_timer_bench.sv ====
// Self-checking bench for the event timer pair
`timescale 1ns/1ns
`include "ret_regs.svh"
`define CHK(nm, ex, got) \
  begin nCompared++; if ((got) !== (ex)) begin errTotal++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module ret_event_timer_bench;
  localparam int unsigned LAG_NS [4] = '{100, 500, 1000, 2000};
  localparam logic [5:0] A_T0ST = 6'h20, A_T1ST = 6'h24, A_T0RL = 6'h2c, A_T1RL = 6'h30;
  localparam logic [5:0] A_T0SU = 6'h38, A_T1SU = 6'h3c;
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  ret_pkg::ret_axi_req_s axiReq = '0;
  ret_pkg::ret_axi_rsp_s axiRsp;
  ret_pkg::ret_rf_s rfIn = '0;
  logic [1:0] protocolSel = 2'h0, bResp, rResp;
  logic [31:0] rData;
  int errTotal = 0, nCompared = 0, cycN = 0;
  ret_event_timer #(.PROTO_DLY_NS0(LAG_NS[0]), .PROTO_DLY_NS1(LAG_NS[1]),
    .PROTO_DLY_NS2(LAG_NS[2]), .PROTO_DLY_NS3(LAG_NS[3])) DUT (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp), .rfIn(rfIn), .protocolSel(protocolSel));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cycN <= cycN + 1;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1; axiReq.awaddr <= a; axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d; axiReq.wstrb <= 4'hf; axiReq.bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end
    while (axiRsp.bvalid !== 1'b1);
    bResp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1; axiReq.araddr <= a; axiReq.rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
    end
    while (axiRsp.rvalid !== 1'b1);
    rData = axiRsp.rdata; rResp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++)
    begin
      rd(i < 2 ? A_T0ST + 6'(4 * i) : i < 4 ? A_T0RL + 6'(4 * (i - 2)) : A_T0SU + 6'(4 * (i - 4)));
      `CHK("reset value", 32'h0, rData)
    end
    wr(A_T0SU, 32'hffffffbe); rd(A_T0SU);
    `CHK("t0 setup", 32'h0000003e, rData)
    wr(A_T1SU, 32'hffffffbe); rd(A_T1SU);
    `CHK("t1 setup", 32'h001ff03e, rData)
    wr(A_T0RL, 32'hfff12345); rd(A_T0RL);
    `CHK("t0 reload", 32'h00012345, rData)
    wr(6'h00, 32'h1);
    `CHK("bad write resp", `RET_RESP_SLVERR, bResp)
    rd(6'h00);
    `CHK("bad read resp", `RET_RESP_SLVERR, rResp)
    wr(A_T0SU, 32'h0); wr(A_T1SU, 32'h0);
  endtask
  // Span is measured by polling, so the window allows for read latency and tick jitter
  task automatic t_span(input logic [2:0] sel, input logic dOn, input int n);
    int t0c, span, ex, slack;
    wr(A_T0RL, 32'(n));
    wr(A_T0SU, {25'h0, 1'b1, sel, dOn, 1'b0, 1'b1});
    t0c = cycN;
    rd(A_T0ST);
    `CHK("t0 started", 1'b1, rData[20])
    while (rData[20] === 1'b1 && cycN - t0c < 5000) rd(A_T0ST);
    span = cycN - t0c;
    ex = n * (dOn ? (2 << sel) : 1) * 20000 / 13560;
    slack = 8 + (dOn ? (4 << sel) : 2);
    `CHK("t0 span", 1'b1, span >= ex - 4 && span <= ex + slack)
    `CHK("t0 end count", 20'h0, rData[19:0])
  endtask
  task automatic t_restart_enable();
    logic [19:0] held;
    wr(A_T0RL, 32'd30); wr(A_T0SU, 32'h43); cyc(200); rd(A_T0ST);
    `CHK("t0 still running", 1'b1, rData[20])
    `CHK("t0 count in range", 1'b1, rData[19:0] != 20'h0 && rData[19:0] <= 20'd30)
    wr(A_T0SU, 32'h0); rd(A_T0ST); held = rData[19:0];
    `CHK("t0 off stops", 1'b0, rData[20])
    cyc(50); rd(A_T0ST);
    `CHK("t0 off holds", held, rData[19:0])
    wr(A_T0SU, 32'h40); cyc(5); rd(A_T0ST);
    `CHK("t0 start while off", 1'b0, rData[20])
  endtask
  task automatic t_halt();
    logic [4:0] ev, pre;
    wr(A_T1RL, 32'h000fffff);
    for (int i = 0; i < 5; i++)
    begin
      ev = 5'h1 << (i < 2 ? 0 : i < 4 ? 1 : 2);
      pre = (i == 0 || i == 2) ? ev : 5'h0;
      rfIn <= pre; cyc(6);
      wr(A_T1SU, (32'h1 << (15 + i)) | 32'h00100041); cyc(4); rd(A_T1ST);
      `CHK("t1 runs before event", 1'b1, rData[20])
      rfIn <= pre ^ ev; cyc(8); rd(A_T1ST);
      `CHK("t1 halted", 1'b0, rData[20])
    end
    for (int i = 0; i < 3; i++)
    begin
      ev = i == 0 ? 5'h04 : 5'h10;
      pre = i == 1 ? ev : 5'h0;
      rfIn <= pre; cyc(6);
      wr(A_T1SU, (32'h1 << (12 + i)) | 32'h1); cyc(4); rd(A_T1ST);
      `CHK("t1 idle before event", 1'b0, rData[20])
      rfIn <= pre ^ ev; cyc(8); rd(A_T1ST);
      `CHK("t1 launched", 1'b1, rData[20])
      wr(A_T1SU, 32'h0);
    end
    rfIn <= '0;
  endtask
  // The lag is loaded at the nibble event, so protocolSel is settled well before it;
  // the first poll samples one cycle ahead of the halt, so a short lag is caught
  task automatic t_rx_lag();
    int d;
    for (int p = 0; p < 4; p++)
    begin
      d = (LAG_NS[p] + 49) / 50;
      protocolSel <= 2'(p); rfIn <= '0; cyc(6);
      wr(A_T1SU, 32'h00100041); rfIn <= 5'h10; cyc(3);
      rfIn <= 5'h18; cyc(d + 1); rd(A_T1ST);
      `CHK("t1 before lag", 1'b1, rData[20])
      cyc(8); rd(A_T1ST);
      `CHK("t1 after lag", 1'b0, rData[20])
    end
    rfIn <= '0; wr(A_T1SU, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compared %0d", errTotal, nCompared);
    if (errTotal == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    cyc(3);
    sys_rst <= 1'b0;
    t_regs();
    t_span(3'h0, 1'b0, 20);
    for (int s = 0; s < 8; s++) t_span(3'(s), 1'b1, 4);
    t_restart_enable();
    t_halt();
    t_rx_lag();
    report_and_stop();
  end
  initial
  begin
    cyc(60000);
    errTotal++;
    $display("[ERR] watchdog expected done seen hang");
    report_and_stop();
  end
endmodule

// ==== verif/ret_event_timer_chk.sv ====
// Bus-side assertions for the event timer pair, bound to its top module
`timescale 1ns/1ns
`include "ret_regs.svh"
module ret_event_timer_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus and RF levels
  input wire ret_pkg::ret_axi_req_s axiReq,
  input wire ret_pkg::ret_axi_rsp_s axiRsp,
  input wire ret_pkg::ret_rf_s rfIn,
  input wire logic [1:0] protocolSel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic rdTake, wrTake;
  assign rdTake = axiReq.arvalid && axiRsp.arready;
  assign wrTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  property p_rd_answer; rdTake |=> axiRsp.rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_block; axiRsp.rvalid |-> !axiRsp.arready; endproperty
  a_rd_block: assert property (p_rd_block) else $error("read taken while busy");
  // Both halves are held for one cycle before the commit, so the answer lags by two
  property p_wr_answer; wrTake |-> ##2 axiRsp.bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_wr_block; axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken while busy");
  property p_status_rd;
    rdTake && axiReq.araddr[5:3] == 3'h4 && !axiReq.araddr[1]
      |=> axiRsp.rdata[31:21] == 11'h0 && axiRsp.rresp == `RET_RESP_OKAY;
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status upper bits set");
  property p_t0_setup_rd; rdTake && axiReq.araddr == 6'h38 |=> axiRsp.rdata[31:6] == 26'h0;
  endproperty
  a_t0_setup_rd: assert property (p_t0_setup_rd) else $error("t0 setup bits");
  property p_t1_setup_rd;
    rdTake && axiReq.araddr == 6'h3c
      |=> axiRsp.rdata[31:21] == 11'h0 && axiRsp.rdata[11:6] == 6'h0;
  endproperty
  a_t1_setup_rd: assert property (p_t1_setup_rd) else $error("t1 setup bits");
  property p_bad_rd;
    rdTake && axiReq.araddr == 6'h0 |=> axiRsp.rresp == `RET_RESP_SLVERR && axiRsp.rdata == 32'h0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read accepted");
  property p_bad_wr;
    wrTake && axiReq.awaddr == 6'h0 |-> ##2 axiRsp.bresp == `RET_RESP_SLVERR;
  endproperty
  a_bad_wr: assert property (p_bad_wr) else $error("unmapped write accepted");
  property p_rst_quiet; $past(sys_rst) |-> !axiRsp.bvalid && !axiRsp.rvalid; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("response after reset");
  c_bad_rd: cover property (rdTake && axiReq.araddr == 6'h0);
  c_status: cover property (rdTake && axiReq.araddr == 6'h24);
  c_nibble: cover property ($rose(rfIn.rxNibble) && protocolSel == 2'h3);
endmodule
bind ret_event_timer ret_event_timer_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .axiReq(axiReq), .axiRsp(axiRsp), .rfIn(rfIn), .protocolSel(protocolSel));
